// ---- src/ulm_link.v ----
// Added by the designer: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "ulm_consts.vh"

// Overview of operation
// RQ1: clear low-power-n bit to enter low power
// RQ2: hold stop to leave low power
// RQ3: restart crystal clock before asserting stop
// RQ4: capture receive command sent after exit
// RQ5: low power: pins 0,1 show line state
// RQ6: pin 3 is interrupt in alternate modes
// RQ7: low power: pins 2, 7..4 device-driven low
// RQ8: set six-pin bit to enter six-pin mode
// RQ9: hold stop to leave six-pin mode
// RQ10: set keep-clock bit before serial mode
// RQ11: six-pin: link drives enable, data, se0
// RQ12: six-pin: pins 4..6 carry receive lines
// RQ13: set three-pin bit to enter three-pin mode
// RQ14: hold stop to leave three-pin mode
// RQ15: three-pin: pin 1 direction follows enable
// RQ16: three-pin: pin 2 direction follows enable
// RQ17: three-pin: pins 7..4 device-driven low
// RQ18: direction stays high in alternate modes
// RQ19: stop held high returns synchronous mode
// RQ20: next signal ignored in alternate modes
// RQ21: mode bits return inactive on exit
module ulm_link (
  input wire ref_clk,
  input wire rst_n,
  input wire [1:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire ulpi_dir,
  input wire ulpi_nxt,
  input wire [7:0] ulpi_data_in,
  output reg [7:0] ulpi_data_out,
  output reg [7:0] ulpi_data_oe,
  output reg ulpi_stp,
  output reg crystal_clk_en
);

  localparam [8:0] ST_IDLE = 9'h001;
  localparam [8:0] ST_TXCMD = 9'h002;
  localparam [8:0] ST_TXDATA = 9'h004;
  localparam [8:0] ST_TXSTP = 9'h008;
  localparam [8:0] ST_ENTER = 9'h010;
  localparam [8:0] ST_ALT = 9'h020;
  localparam [8:0] ST_XTAL = 9'h040;
  localparam [8:0] ST_STOP = 9'h080;
  localparam [8:0] ST_POST = 9'h100;
  localparam integer XTAL_CYC_W = `ULM_XTAL_START_CYC;
  localparam integer POST_CYC_W = `ULM_POST_WAIT_CYC;
  localparam [11:0] XTAL_CYC = XTAL_CYC_W[11:0];
  localparam [11:0] POST_CYC = POST_CYC_W[11:0];

  reg [8:0] state_ff, nxt_state;
  reg [6:0] ctrl_ff;
  reg [2:0] cmd_ff, nxt_cmd;
  reg [1:0] mode_ff, nxt_mode;
  reg [1:0] target_ff, nxt_target;
  reg [7:0] wr_addr_ff, nxt_wr_addr;
  reg [7:0] wr_data_ff, nxt_wr_data;
  reg [11:0] cnt_ff, nxt_cnt;
  reg dir_q_ff;
  reg [7:0] rxcmd_ff;
  reg rxcmd_valid_ff;
  reg [7:0] nxt_data_out, nxt_data_oe;
  reg nxt_stp, nxt_xtal;
  reg [31:0] nxt_readdata;
  wire bus_req;
  wire bus_ack;
  wire rxcmd_seen;
  wire busy;
  wire [7:0] pins;

  assign pins = ulpi_data_in;
  assign bus_req = avs_read | avs_write;
  assign bus_ack = bus_req & ~avs_waitrequest;
  assign busy = (state_ff != ST_IDLE) && (state_ff != ST_ALT);
  // receive command: direction high past turnaround, next low, sync mode only
  assign rxcmd_seen = ulpi_dir & dir_q_ff & ~ulpi_nxt &
    (mode_ff == `ULM_MODE_SYNC); // [RQ4] [RQ20]

  //////////////////////////////////////////////////////////////////////////////
  // avalon slave: one wait cycle, answer at the second edge
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else begin
      if (bus_req && avs_waitrequest) begin
        avs_waitrequest <= 1'b0;
      end else begin
        avs_waitrequest <= 1'b1;
      end
      avs_readdata <= nxt_readdata;
    end
  end

  always @* begin
    nxt_readdata = avs_readdata;
    if (avs_read && avs_waitrequest) begin
      case (avs_address)
        `ULM_IDX_CTRL: nxt_readdata = {25'h0000000, ctrl_ff};
        `ULM_IDX_CMD: nxt_readdata = {29'h00000000, cmd_ff};
        `ULM_IDX_STATUS: nxt_readdata = {8'h00, pins, 3'h0, busy, mode_ff,
          crystal_clk_en, ulpi_dir, state_ff[7:0]};
        `ULM_IDX_RXCMD: nxt_readdata = {23'h000000, rxcmd_valid_ff, rxcmd_ff};
        default: nxt_readdata = 32'h00000000;
      endcase
    end
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= `ULM_CTRL_RESET;
      rxcmd_ff <= 8'h00;
      rxcmd_valid_ff <= 1'b0;
      dir_q_ff <= 1'b0;
    end else begin
      dir_q_ff <= ulpi_dir;
      if (avs_write && bus_ack && avs_address == `ULM_IDX_CTRL) begin
        ctrl_ff <= avs_writedata[6:0];
      end
      if (rxcmd_seen) begin
        rxcmd_ff <= pins; // [RQ4]
        rxcmd_valid_ff <= 1'b1;
      end else if (avs_write && bus_ack && avs_address == `ULM_IDX_RXCMD) begin
        rxcmd_valid_ff <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // mode sequencer
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
      cmd_ff <= `ULM_CMD_NONE;
      mode_ff <= `ULM_MODE_SYNC;
      target_ff <= `ULM_MODE_SYNC;
      wr_addr_ff <= 8'h00;
      wr_data_ff <= 8'h00;
      cnt_ff <= 12'h000;
      ulpi_data_out <= 8'h00;
      ulpi_data_oe <= 8'h00;
      ulpi_stp <= 1'b0;
      crystal_clk_en <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      cmd_ff <= nxt_cmd;
      mode_ff <= nxt_mode;
      target_ff <= nxt_target;
      wr_addr_ff <= nxt_wr_addr;
      wr_data_ff <= nxt_wr_data;
      cnt_ff <= nxt_cnt;
      ulpi_data_out <= nxt_data_out;
      ulpi_data_oe <= nxt_data_oe;
      ulpi_stp <= nxt_stp;
      crystal_clk_en <= nxt_xtal;
    end
  end

  always @* begin
    nxt_state = state_ff;
    nxt_cmd = cmd_ff;
    nxt_mode = mode_ff;
    nxt_target = target_ff;
    nxt_wr_addr = wr_addr_ff;
    nxt_wr_data = wr_data_ff;
    nxt_cnt = cnt_ff;
    nxt_data_out = 8'h00;
    nxt_data_oe = 8'h00;
    nxt_stp = 1'b0;
    nxt_xtal = crystal_clk_en;
    if (avs_write && bus_ack && avs_address == `ULM_IDX_CMD &&
        cmd_ff == `ULM_CMD_NONE) begin
      nxt_cmd = avs_writedata[2:0];
    end
    case (state_ff)
      ST_IDLE: begin
        nxt_data_oe = ulpi_dir ? 8'h00 : 8'hff;
        if (!ulpi_dir && !dir_q_ff) begin
          case (cmd_ff)
            `ULM_CMD_LOW_POWER: begin
              nxt_wr_addr = {`ULM_TXCMD_REGWR, `ULM_ADDR_FUNCTION_CONTROL_REG_CLR};
              nxt_wr_data = 8'h01 << `ULM_FUNC_LOW_POWER_N_BIT; // [RQ1]
              nxt_target = `ULM_MODE_LOW_POWER;
              nxt_state = ST_TXCMD;
            end
            `ULM_CMD_SIX_PIN: begin
              nxt_wr_addr = {`ULM_TXCMD_REGWR, `ULM_ADDR_INTERFACE_CONTROL_REG_SET};
              nxt_wr_data = (8'h01 << `ULM_INTF_SIX_PIN_BIT) |
                ({7'h00, ctrl_ff[`ULM_CTRL_KEEP_CLK]} << `ULM_INTF_KEEP_CLK_BIT); // [RQ8] [RQ10]
              nxt_target = `ULM_MODE_SIX_PIN;
              nxt_state = ST_TXCMD;
            end
            `ULM_CMD_THREE_PIN: begin
              nxt_wr_addr = {`ULM_TXCMD_REGWR, `ULM_ADDR_INTERFACE_CONTROL_REG_SET};
              nxt_wr_data = (8'h01 << `ULM_INTF_THREE_PIN_BIT) |
                ({7'h00, ctrl_ff[`ULM_CTRL_KEEP_CLK]} << `ULM_INTF_KEEP_CLK_BIT); // [RQ13] [RQ10]
              nxt_target = `ULM_MODE_THREE_PIN;
              nxt_state = ST_TXCMD;
            end
            `ULM_CMD_NONE: nxt_state = ST_IDLE;
            default: nxt_cmd = `ULM_CMD_NONE;
          endcase
          if (nxt_state == ST_TXCMD) begin
            nxt_data_out = nxt_wr_addr;
            nxt_cmd = `ULM_CMD_NONE;
          end
        end
      end
      ST_TXCMD: begin
        nxt_data_oe = 8'hff;
        nxt_data_out = wr_addr_ff;
        if (ulpi_dir) begin
          nxt_data_oe = 8'h00;
          nxt_state = ST_IDLE;
          nxt_cmd = target_ff == `ULM_MODE_LOW_POWER ? `ULM_CMD_LOW_POWER :
            (target_ff == `ULM_MODE_SIX_PIN ? `ULM_CMD_SIX_PIN : `ULM_CMD_THREE_PIN);
        end else if (ulpi_nxt) begin
          nxt_data_out = wr_data_ff;
          nxt_state = ST_TXDATA;
        end
      end
      ST_TXDATA: begin
        nxt_data_oe = 8'hff;
        nxt_data_out = wr_data_ff;
        if (ulpi_nxt) begin
          nxt_data_out = 8'h00;
          nxt_stp = 1'b1;
          nxt_state = ST_TXSTP;
        end
      end
      ST_TXSTP: begin
        nxt_cnt = POST_CYC;
        nxt_state = ST_ENTER;
      end
      ST_ENTER: begin
        nxt_cnt = cnt_ff - 12'h001;
        if (ulpi_dir) begin
          nxt_mode = target_ff;
          nxt_state = ST_ALT;
          if (target_ff == `ULM_MODE_LOW_POWER && ctrl_ff[`ULM_CTRL_XTAL_STOP]) begin
            nxt_xtal = 1'b0; // [RQ3]
          end
        end else if (cnt_ff == 12'h000) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_ALT: begin
        // pins 3..7 and low-power pins all belong to the device
        case (mode_ff)
          `ULM_MODE_SIX_PIN: begin
            nxt_data_oe = 8'h07; // [RQ11] [RQ12]
            nxt_data_out = {5'h00, ctrl_ff[`ULM_CTRL_TXSE0], ctrl_ff[`ULM_CTRL_TXDAT],
              ctrl_ff[`ULM_CTRL_TXEN]};
          end
          `ULM_MODE_THREE_PIN: begin
            nxt_data_oe = {5'h00, {2{ctrl_ff[`ULM_CTRL_TXEN]}}, 1'b1}; // [RQ15] [RQ16] [RQ17]
            nxt_data_out = {5'h00, ctrl_ff[`ULM_CTRL_TXSE0], ctrl_ff[`ULM_CTRL_TXDAT],
              ctrl_ff[`ULM_CTRL_TXEN]};
          end
          default: nxt_data_oe = 8'h00; // [RQ5] [RQ6] [RQ7]
        endcase
        if (cmd_ff == `ULM_CMD_EXIT) begin
          nxt_cmd = `ULM_CMD_NONE;
          nxt_data_oe = 8'h00;
          if (!crystal_clk_en) begin
            nxt_xtal = 1'b1; // [RQ3]
            nxt_cnt = XTAL_CYC;
            nxt_state = ST_XTAL;
          end else begin
            nxt_stp = 1'b1;
            nxt_state = ST_STOP;
          end
        end else if (cmd_ff != `ULM_CMD_NONE) begin
          nxt_cmd = `ULM_CMD_NONE;
        end else if (!ulpi_dir) begin
          nxt_mode = `ULM_MODE_SYNC; // [RQ18] [RQ21]
          nxt_state = ST_IDLE;
        end
      end
      ST_XTAL: begin
        nxt_cnt = cnt_ff - 12'h001;
        if (cnt_ff <= 12'h001) begin
          nxt_stp = 1'b1; // [RQ3]
          nxt_state = ST_STOP;
        end
      end
      ST_STOP: begin
        nxt_stp = 1'b1; // [RQ2] [RQ9] [RQ14] [RQ19]
        if (!ulpi_dir) begin
          nxt_stp = 1'b0;
          nxt_mode = `ULM_MODE_SYNC; // [RQ21]
          nxt_cnt = POST_CYC;
          nxt_state = ST_POST;
        end
      end
      ST_POST: begin
        nxt_cnt = cnt_ff - 12'h001;
        if (rxcmd_seen || cnt_ff == 12'h000) begin
          nxt_state = ST_IDLE; // [RQ4]
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

endmodule

// ---- src/ulm_consts.vh ----
`ifndef ULM_CONSTS_VH
`define ULM_CONSTS_VH
// avalon word offsets (byte address = 4 * index)
`define ULM_IDX_CTRL 2'h0
`define ULM_IDX_CMD 2'h1
`define ULM_IDX_STATUS 2'h2
`define ULM_IDX_RXCMD 2'h3
// ctrl register fields
`define ULM_CTRL_KEEP_CLK 0
`define ULM_CTRL_XTAL_STOP 1
`define ULM_CTRL_TXEN 4
`define ULM_CTRL_TXDAT 5
`define ULM_CTRL_TXSE0 6
`define ULM_CTRL_RESET 7'h00
// command codes
`define ULM_CMD_NONE 3'h0
`define ULM_CMD_LOW_POWER 3'h1
`define ULM_CMD_SIX_PIN 3'h2
`define ULM_CMD_THREE_PIN 3'h3
`define ULM_CMD_EXIT 3'h4
// mode codes
`define ULM_MODE_SYNC 2'h0
`define ULM_MODE_LOW_POWER 2'h1
`define ULM_MODE_SIX_PIN 2'h2
`define ULM_MODE_THREE_PIN 2'h3
// ulpi transmit command and device register addresses
`define ULM_TXCMD_REGWR 2'h2
`define ULM_ADDR_FUNCTION_CONTROL_REG_CLR 6'h06
`define ULM_ADDR_INTERFACE_CONTROL_REG_SET 6'h08
`define ULM_FUNC_LOW_POWER_N_BIT 6
`define ULM_INTF_SIX_PIN_BIT 0
`define ULM_INTF_THREE_PIN_BIT 1
`define ULM_INTF_KEEP_CLK_BIT 3
// timing
`define ULM_CLK_PERIOD_NS 4
`define ULM_XTAL_START_NS 1000
`define ULM_XTAL_START_CYC ((`ULM_XTAL_START_NS + `ULM_CLK_PERIOD_NS - 1) / `ULM_CLK_PERIOD_NS)
`define ULM_POST_WAIT_NS 1024
`define ULM_POST_WAIT_CYC (`ULM_POST_WAIT_NS / `ULM_CLK_PERIOD_NS)
`endif

// ---- dv/ulm_link_props.sv ----
`timescale 1ns/1ps
module ulm_link_props (
  input wire ref_clk,
  input wire rst_n,
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest,
  input wire ulpi_dir,
  input wire [7:0] ulpi_data_oe,
  input wire ulpi_stp,
  input wire crystal_clk_en
);
  reg [7:0] xcnt_ff;
  // cycles since crystal restart
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) xcnt_ff <= 8'hff;
    else if (!crystal_clk_en) xcnt_ff <= 8'h00;
    else if (xcnt_ff != 8'hff) xcnt_ff <= xcnt_ff + 8'h01;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("no answer one cycle after request");
  a_upper_pins_in: assert property (ulpi_dir && $past(ulpi_dir) |-> ulpi_data_oe[7:3] == 5'h00)
    else $error("link drives device pins");
  a_dat_se0_pair: assert property (ulpi_dir && $past(ulpi_dir) |-> ulpi_data_oe[2] == ulpi_data_oe[1])
    else $error("pin 1 and pin 2 owners differ");
  a_stop_hold: assert property (ulpi_stp && ulpi_dir |=> ulpi_stp)
    else $error("stop dropped while dir high");
  a_stop_release: assert property (ulpi_stp && !ulpi_dir |-> ##[1:2] !ulpi_stp)
    else $error("stop not released");
  a_stop_bus_free: assert property (ulpi_stp && ulpi_dir |-> ulpi_data_oe == 8'h00)
    else $error("bus driven during wake");
  a_xtal_first: assert property ($rose(ulpi_stp) && ulpi_dir |-> xcnt_ff >= 8'd249)
    else $error("stop before crystal settled");
  c_wake: cover property (ulpi_stp && ulpi_dir);
  c_xtal_off: cover property ($fell(crystal_clk_en));
  c_six: cover property (ulpi_dir && ulpi_data_oe == 8'h07);
endmodule
bind ulm_link ulm_link_props chk_u (.ref_clk(ref_clk), .rst_n(rst_n), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .ulpi_dir(ulpi_dir),
  .ulpi_data_oe(ulpi_data_oe), .ulpi_stp(ulpi_stp), .crystal_clk_en(crystal_clk_en));

// ---- dv/ulm_dev_model.sv ----
`timescale 1ns/1ps
module ulm_dev_model #(
  parameter [7:0] RXV = 8'h5a
) (
  input wire clk,
  input wire rst_n,
  input wire stp,
  input wire xtal_en,
  input wire intr,
  input wire [3:0] ana,
  input wire [7:0] bus,
  output reg dir,
  output reg nxt,
  output reg [7:0] dev_oe,
  output reg [7:0] dev_d
);
  reg [1:0] mode_ff;
  reg [5:0] addr_ff;
  reg [7:0] wr_dat_ff;
  integer st_ff;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= 0; dir <= 0; nxt <= 0; mode_ff <= 0; addr_ff <= 0; wr_dat_ff <= 0;
    end else case (st_ff)
      0: if (bus[7:6] == 2'h2) begin
        addr_ff <= bus[5:0]; nxt <= 1; st_ff <= 1;
      end
      1: st_ff <= 2;
      2: begin
        wr_dat_ff <= bus; nxt <= 0; st_ff <= 3;
      end
      3: if (stp) begin
        if (addr_ff == 6'h06 && wr_dat_ff[6]) mode_ff <= 2'h1;
        else mode_ff <= wr_dat_ff[1] ? 2'h3 : 2'h2;
        dir <= 1; st_ff <= 4;
      end
      4: begin
        nxt <= ~nxt;
        if (stp && xtal_en) begin
          dir <= 0; nxt <= 0; mode_ff <= 0; st_ff <= 5;
        end
      end
      5: if (!stp) begin
        dir <= intr; st_ff <= intr ? 6 : 0;
      end
      6, 7: st_ff <= st_ff + 1;
      default: begin
        dir <= 0; st_ff <= 0;
      end
    endcase
  end
  // pin map per mode
  always @* begin
    dev_oe = 8'h00; dev_d = 8'h00;
    if (dir && mode_ff == 2'h0) begin
      dev_oe = 8'hff; dev_d = RXV;
    end else if (mode_ff == 2'h1) begin
      dev_oe = 8'hff; dev_d = {4'h0, intr, 1'b0, ana[1:0]};
    end else if (mode_ff == 2'h2) begin
      dev_oe = 8'hf8; dev_d = {1'b0, ana[2:0], intr, 3'h0};
    end else if (mode_ff == 2'h3) begin
      dev_oe = {5'h1f, {2{~bus[0]}}, 1'b0};
      dev_d = {4'h0, intr, ana[3:2], 1'b0};
    end
  end
endmodule

// ---- dv/test_ulpi_alt_bus_modes.sv ----
`timescale 1ns/1ps
`include "ulm_consts.vh"
module test_ulpi_alt_bus_modes;
  logic ref_clk, rst_n, avs_read, avs_write, avs_waitrequest, intr, tog;
  logic ulpi_dir, ulpi_nxt, ulpi_stp, crystal_clk_en;
  logic [1:0] avs_address;
  logic [3:0] ana;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [7:0] l_out, l_oe, d_oe, d_d;
  wire [7:0] bus = (l_oe & l_out) | (d_oe & d_d) | (~(l_oe | d_oe) & {8{tog}});
  integer fails, total_checks, i;
  // cmd, ctrl, analog lines, interrupt, expected pins
  logic [22:0] rows [6] = '{{3'h1, 7'h02, 4'h1, 1'b1, 8'h09}, {3'h1, 7'h00, 4'h2, 1'b0, 8'h02},
    {3'h2, 7'h51, 4'h6, 1'b1, 8'h6d}, {3'h2, 7'h20, 4'h1, 1'b0, 8'h12},
    {3'h3, 7'h01, 4'h8, 1'b1, 8'h0c}, {3'h3, 7'h30, 4'h4, 1'b0, 8'h03}};
  ulm_link dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ulpi_dir(ulpi_dir),
    .ulpi_nxt(ulpi_nxt), .ulpi_data_in(bus), .ulpi_data_out(l_out), .ulpi_data_oe(l_oe),
    .ulpi_stp(ulpi_stp), .crystal_clk_en(crystal_clk_en));
  ulm_dev_model dev_u (.clk(ref_clk), .rst_n(rst_n), .stp(ulpi_stp), .xtal_en(crystal_clk_en),
    .intr(intr), .ana(ana), .bus(bus), .dir(ulpi_dir), .nxt(ulpi_nxt), .dev_oe(d_oe),
    .dev_d(d_d));
  initial begin
    ref_clk = 0;
    forever #2 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) tog <= ~tog;
  ////////////////////////////////////////////////////////////////
  task complete_run;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task av(input logic wr, input logic [1:0] a, input logic [31:0] d, output logic [31:0] rd);
    integer k;
    avs_address <= a; avs_writedata <= d; avs_write <= wr; avs_read <= !wr;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (avs_waitrequest && k < 50);
    if (avs_waitrequest) begin
      fails++;
      complete_run;
    end
    rd = avs_readdata;
    avs_read <= 0; avs_write <= 0;
    @(posedge ref_clk);
  endtask
  task wstat(input logic [2:0] e, input logic [2:0] m);
    integer k;
    k = 0;
    do begin
      av(0, `ULM_IDX_STATUS, 0, q);
      k++;
    end while ((q[12:10] & m) !== e && k < 400);
    if ((q[12:10] & m) !== e) begin
      fails++;
      complete_run;
    end
  endtask
  task run_row(input logic [22:0] r);
    logic [2:0] c;
    logic [6:0] ct;
    c = r[22:20]; ct = r[19:13];
    ana <= r[12:9]; intr <= r[8];
    av(1, `ULM_IDX_RXCMD, 0, q);
    av(1, `ULM_IDX_CTRL, ct, q);
    av(1, `ULM_IDX_CMD, c, q);
    wstat({1'b0, c[1:0]}, 3'h3);
    chk(dev_u.wr_dat_ff, c == 3'h1 ? 8'h40 : {ct[0], 1'b0, c == 3'h3, c == 3'h2});
    repeat (4) @(posedge ref_clk);
    chk(bus, r[7:0]);
    chk(crystal_clk_en, !(ct[1] && c == 3'h1));
    av(1, `ULM_IDX_CMD, `ULM_CMD_EXIT, q);
    if (ct[1] && c == 3'h1) begin
      repeat (4) @(posedge ref_clk);
      av(0, `ULM_IDX_RXCMD, 0, q);
      chk(q[8], 1'b0);
    end
    wstat(3'h0, 3'h7);
    chk(q[9], 1'b1);
    av(0, `ULM_IDX_RXCMD, 0, q);
    chk(q[8], r[8]);
    if (r[8]) chk(q[7:0], dev_u.RXV);
    $display("row test done");
  endtask
  initial begin
    fails = 0; total_checks = 0; tog = 0; rst_n = 0; intr = 0; ana = 0;
    avs_read = 0; avs_write = 0; avs_address = 0; avs_writedata = 0;
    repeat (8) @(posedge ref_clk);
    chk({avs_waitrequest, ulpi_stp, crystal_clk_en, l_oe}, {3'h5, 8'h00});
    $display("reset test done");
    rst_n <= 1;
    @(posedge ref_clk);
    for (i = 0; i < 6; i++) run_row(rows[i]);
    // exit request with no alternate mode is dropped
    av(1, `ULM_IDX_CMD, `ULM_CMD_EXIT, q);
    repeat (8) @(posedge ref_clk);
    av(0, `ULM_IDX_CMD, 0, q);
    chk({q[2:0], ulpi_stp}, 0);
    $display("idle exit test done");
    complete_run;
  end
  initial begin
    repeat (100000) @(posedge ref_clk);
    fails++;
    complete_run;
  end
endmodule
